// *** dv/sdc_ctrl_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sdc_ctrl_model import sdc_pkg::*; (
  input  wire sdc_cmd_e          i_cmd,
  input  wire logic              i_clock,
  input  wire logic [1:0]        i_bank,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic              i_cke,
  output var  sdc_pins_s         o_pins
);
  logic flip = 1'b0;
  // Ignored pins toggle, so a stale value can never pass for a valid one
  always @(posedge i_clock) flip <= ~flip;
  always_comb begin
    o_pins = '{1'b0, 1'b1, 1'b1, 1'b1, i_cke, i_bank, i_addr};
    case (i_cmd)
      CMD_DESELECT_IGNORE: o_pins = '{1'b1, flip, ~flip, flip, i_cke, {2{flip}}, {ADDR_W{flip}}};
      CMD_IDLE_CYCLE: o_pins.addr = {ADDR_W{flip}};
      CMD_BURST_HALT: o_pins.we_b = 1'b0;
      CMD_READ: o_pins.cas_b = 1'b0;
      CMD_STORE_BURST: {o_pins.cas_b, o_pins.we_b} = 2'h0;
      CMD_ROW_OPEN: o_pins.ras_b = 1'b0;
      CMD_BANK_CLOSE, CMD_CLOSE_ALL_BANKS: begin
        {o_pins.ras_b, o_pins.we_b} = 2'h0;
        o_pins.addr[AUTOCLOSE_BIT] = (i_cmd == CMD_CLOSE_ALL_BANKS);
      end
      // clock enable picks the refresh kind
      CMD_ROW_RENEWAL, CMD_RETENTION: begin
        {o_pins.ras_b, o_pins.cas_b} = 2'h0;
        o_pins.cke = i_cke && (i_cmd == CMD_ROW_RENEWAL);
      end
      CMD_MODE_LOAD, CMD_EXT_MODE_LOAD: begin
        {o_pins.ras_b, o_pins.cas_b, o_pins.we_b} = 3'h0;
        o_pins.bank_sel = (i_cmd == CMD_MODE_LOAD) ? SEL_MODE : SEL_EXT_MODE;
      end
      default: o_pins.cs_b = 1'b0;
    endcase
  end
endmodule : sdc_ctrl_model
`default_nettype wire

// *** dv/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench import sdc_pkg::*;;
  logic                        i_clock = 1'b0;
  logic                        i_rst_b = 1'b0;
  logic                        cke = 1'b1;
  sdc_cmd_e                    cmd = CMD_DESELECT_IGNORE;
  logic [1:0]                  bank = 2'h0;
  logic [ADDR_W-1:0]           addr = '0;
  sdc_pins_s                   pins;
  sdc_bank_e [NBANK-1:0]       o_bank_state;
  logic [NBANK-1:0][ROW_W-1:0] o_row;
  sdc_burst_s                  o_burst;
  logic                        o_dq_oe;
  logic                        o_illegal;
  logic [ADDR_W-1:0]           o_mode;
  logic [ADDR_W-1:0]           o_ext_mode;
  int                          n_mismatch = 0;
  int                          n_tests = 0;

  always #5 i_clock = ~i_clock;

  sdc_ctrl_model sdc_ctrl_model_i (.i_cmd(cmd), .i_clock(i_clock), .i_bank(bank), .i_addr(addr),
    .i_cke(cke), .o_pins(pins));
  sdc_command_bank_fsm sdc_command_bank_fsm_i (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_pins(pins),
    .o_bank_state(o_bank_state), .o_row(o_row), .o_burst(o_burst), .o_dq_oe(o_dq_oe),
    .o_mode(o_mode), .o_ext_mode(o_ext_mode), .o_illegal(o_illegal));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One command per cycle, changed at the falling edge
  task automatic go(input sdc_cmd_e c, input logic [1:0] b = 2'h0, input logic [ADDR_W-1:0] a = '0);
    @(negedge i_clock);
    cmd = c;
    bank = b;
    addr = a;
  endtask : go

  task automatic idle_cycle(input int n);
    repeat (n) go(CMD_IDLE_CYCLE);
  endtask : idle_cycle

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  task automatic t_mode();
    go(CMD_MODE_LOAD, 2'h0, 13'h0032);
    go(CMD_EXT_MODE_LOAD, 2'h0, 13'h0003);
    chk("mode", o_mode, 13'h0032);
    go(CMD_READ, 2'h1, 13'h0000);
    chk("ext_mode", o_ext_mode, 13'h0003);
    chk("illegal", o_illegal, 1'b0);
    idle_cycle(1);
    chk("illegal", o_illegal, 1'b1);
    go(CMD_MODE_LOAD, 2'h0, 13'h0400);
    go(CMD_BURST_HALT);
    chk("bad_mode", o_illegal, 1'b1);
    idle_cycle(1);
    chk("halt_idle", o_illegal, 1'b0);
    chk("mode", o_mode, 13'h0032);
    chk("burst", o_burst.active, 1'b0);
    $display("test mode done");
  endtask : t_mode

  task automatic t_read();
    go(CMD_ROW_OPEN, 2'h1, 13'h1abc);
    go(CMD_READ, 2'h1, 13'h0000);
    chk("actvtg", o_bank_state[1], BK_ACTVTG);
    chk("row", o_row[1], 13'h1abc);
    idle_cycle(1);
    chk("illegal", o_illegal, 1'b1);
    go(CMD_READ, 2'h1, 13'h0405);
    chk("active", o_bank_state[1], BK_ACTIVE);
    idle_cycle(1);
    chk("burst", o_burst, sdc_burst_s'{1'b1, 1'b0, 1'b1, 2'h1, 10'h005});
    chk("dq_oe", o_dq_oe, 1'b1);
    idle_cycle(3);
    chk("dq_oe", o_dq_oe, 1'b1);
    idle_cycle(1);
    chk("dq_oe", o_dq_oe, 1'b0);
    chk("autoclose", o_bank_state[1], BK_PRECHG);
    idle_cycle(2);
    chk("idle", o_bank_state[1], BK_IDLE);
    $display("test read done");
  endtask : t_read

  task automatic t_write();
    go(CMD_ROW_OPEN, 2'h2, 13'h0077);
    idle_cycle(2);
    go(CMD_STORE_BURST, 2'h2, 13'h0009);
    go(CMD_BURST_HALT);
    chk("burst", o_burst, sdc_burst_s'{1'b1, 1'b1, 1'b0, 2'h2, 10'h009});
    chk("dq_oe", o_dq_oe, 1'b0);
    go(CMD_ROW_OPEN, 2'h2, 13'h0000);
    chk("halt", o_burst.active, 1'b0);
    idle_cycle(1);
    chk("illegal", o_illegal, 1'b1);
    idle_cycle(3);
    chk("row", o_row[2], 13'h0077);
    go(CMD_CLOSE_ALL_BANKS, 2'h0);
    idle_cycle(1);
    chk("closed", o_bank_state[2], BK_PRECHG);
    idle_cycle(2);
    $display("test write done");
  endtask : t_write

  // write with autoclose waits for recovery
  task automatic t_wa();
    go(CMD_ROW_OPEN, 2'h3, 13'h0001);
    idle_cycle(2);
    go(CMD_STORE_BURST, 2'h3, 13'h0410);
    idle_cycle(1);
    chk("burst", o_burst, sdc_burst_s'{1'b1, 1'b1, 1'b1, 2'h3, 10'h010});
    idle_cycle(6);
    chk("recovery", o_bank_state[3], BK_ACTIVE);
    idle_cycle(1);
    chk("closed", o_bank_state[3], BK_PRECHG);
    idle_cycle(2);
    $display("test write autoclose done");
  endtask : t_wa

  task automatic t_banks();
    for (int b = 0; b < NBANK; b++) go(CMD_ROW_OPEN, 2'(b), 13'(13'h100 + b));
    idle_cycle(3);
    for (int b = 0; b < NBANK; b++) chk("row", o_row[b], 13'h100 + b);
    for (int b = 0; b < NBANK; b++) begin
      go(CMD_BANK_CLOSE, 2'(b));
      idle_cycle(1);
      chk("closed", o_bank_state[b], BK_PRECHG);
      if (b < 3) chk("open", o_bank_state[b+1], BK_ACTIVE);
    end
    idle_cycle(2);
    chk("idle", o_bank_state[3], BK_IDLE);
    $display("test banks done");
  endtask : t_banks

  task automatic t_refresh();
    go(CMD_ROW_RENEWAL);
    go(CMD_ROW_OPEN, 2'h0);
    for (int b = 0; b < NBANK; b++) chk("refresh", o_bank_state[b], BK_REFRESH);
    idle_cycle(1);
    chk("illegal", o_illegal, 1'b1);
    idle_cycle(13);
    chk("refresh", o_bank_state[0], BK_REFRESH);
    idle_cycle(1);
    chk("idle", o_bank_state[0], BK_IDLE);
    cke = 1'b0;
    go(CMD_RETENTION);
    idle_cycle(4);
    chk("retain", o_bank_state[2], BK_REFRESH);
    cke = 1'b1;
    idle_cycle(2);
    chk("idle", o_bank_state[2], BK_IDLE);
    $display("test refresh done");
  endtask : t_refresh

  // Main sequence
  initial begin
    repeat (6) @(negedge i_clock);
    i_rst_b = 1'b1;
    chk("reset", o_bank_state, {NBANK{BK_IDLE}});
    chk("reset", o_dq_oe, 1'b0);
    t_mode();
    t_read();
    t_write();
    t_wa();
    t_banks();
    t_refresh();
    summarize();
  end

  // Whole run is under a hundred cycles
  initial begin
    #20us;
    n_mismatch++;
    summarize();
  end
endmodule : testbench
`default_nettype wire

// *** rtl/sdc_bank.sv ***
`timescale 1ns/1ps
`default_nettype none
module sdc_bank import sdc_pkg::*; (
  input  wire logic      i_clock,
  input  wire logic      i_rst_b,
  input  wire logic      i_open,
  input  wire logic      i_close,
  input  wire logic      i_refresh,
  input  wire logic      i_retain,
  input  wire logic      i_cke,
  output var  sdc_bank_e o_state
);

  localparam int PRE_D = TRP_CYC;
  localparam int ACT_D = TRCD_CYC;

  sdc_bank_s cur;
  sdc_bank_s next_cur;

  // ****************************************
  // Bank state machine
  // ****************************************
  always_comb begin
    next_cur = cur;
    if (cur.cnt != 4'h0) begin
      next_cur.cnt = cur.cnt - 4'h1;
    end
    case (cur.st)
      BK_PRECHG: if (cur.cnt == 4'h0) begin
        next_cur.st = BK_IDLE;
      end
      BK_IDLE: begin
        if (i_open) begin
          next_cur.st  = BK_ACTVTG;
          next_cur.cnt = TRCD_LOAD;
        end else if (i_refresh) begin
          next_cur.st     = BK_REFRESH;
          next_cur.cnt    = TRFC_LOAD;
          next_cur.retain = 1'b0;
        end else if (i_retain) begin
          next_cur.st     = BK_REFRESH;
          next_cur.retain = 1'b1;
        end
      end
      BK_REFRESH: if (cur.retain ? i_cke : (cur.cnt == 4'h0)) begin
        next_cur.st     = BK_IDLE;
        next_cur.retain = 1'b0;
      end
      BK_ACTVTG: if (cur.cnt == 4'h0) begin
        next_cur.st = BK_ACTIVE;
      end
      BK_ACTIVE: if (i_close) begin
        next_cur.st  = BK_PRECHG;
        next_cur.cnt = TRP_LOAD;
      end
      default: next_cur = BANK_RST;
    endcase
  end

  // State register
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      cur <= BANK_RST;
    end else begin
      cur <= next_cur;
    end
  end

  assign o_state = cur.st;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  precharge_time_a: assert property (
    (o_state == BK_ACTIVE) && i_close |=> (o_state == BK_PRECHG) ##PRE_D (o_state == BK_IDLE))
    else $error("precharge time wrong");
  activate_time_a: assert property (
    (o_state == BK_IDLE) && i_open |=> (o_state == BK_ACTVTG) ##ACT_D (o_state == BK_ACTIVE))
    else $error("activate time wrong");
  refresh_time_a: assert property (
    (o_state == BK_IDLE) && !i_open && i_refresh |=> (o_state == BK_REFRESH) ##15 (o_state == BK_IDLE))
    else $error("refresh time wrong");

endmodule : sdc_bank
`default_nettype wire

// *** rtl/sdc_cmd_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
module sdc_cmd_decode import sdc_pkg::*; (
  input  wire sdc_pins_s i_pins,
  output var  sdc_cmd_s  o_cmd
);

  // Pin levels to command; deselect wins over everything
  always_comb begin
    o_cmd.bank      = i_pins.bank_sel;
    o_cmd.autoclose = i_pins.addr[AUTOCLOSE_BIT];
    o_cmd.addr      = i_pins.addr;
    if (i_pins.cs_b) begin
      o_cmd.cmd = CMD_DESELECT_IGNORE;
    end else begin
      case ({i_pins.ras_b, i_pins.cas_b, i_pins.we_b})
        3'h7: o_cmd.cmd = CMD_IDLE_CYCLE;
        3'h6: o_cmd.cmd = CMD_BURST_HALT;
        3'h5: o_cmd.cmd = CMD_READ;
        3'h4: o_cmd.cmd = CMD_STORE_BURST;
        3'h3: o_cmd.cmd = CMD_ROW_OPEN;
        3'h2: o_cmd.cmd = i_pins.addr[AUTOCLOSE_BIT] ? CMD_CLOSE_ALL_BANKS : CMD_BANK_CLOSE;
        // Clock enable picks the refresh kind
        3'h1: o_cmd.cmd = i_pins.cke ? CMD_ROW_RENEWAL : CMD_RETENTION;
        3'h0: begin
          if (i_pins.addr[AUTOCLOSE_BIT]) begin
            o_cmd.cmd = CMD_BAD;
          end else if (i_pins.bank_sel == SEL_MODE) begin
            o_cmd.cmd = CMD_MODE_LOAD;
          end else if (i_pins.bank_sel == SEL_EXT_MODE) begin
            o_cmd.cmd = CMD_EXT_MODE_LOAD;
          end else begin
            o_cmd.cmd = CMD_BAD;
          end
        end
        default: o_cmd.cmd = CMD_BAD;
      endcase
    end
  end

endmodule : sdc_cmd_decode
`default_nettype wire

// *** rtl/sdc_command_bank_fsm.sv ***
// What this block does
// - Idle cycle ignores address and data; no internal state changes.
// - Burst halt ends the read or write burst in progress unless it has autoclose.
// - Read starts burst at column and bank; drivers released when done.
// - Read with autoclose closes its bank by itself after the burst.
// - Store burst starts a write burst at column and bank given.
// - Store burst with autoclose closes the bank after write completes.
// - Row open activates selected bank and latches its row address.
// - Bank close closes only the bank picked by the two select bits.
// - Close all banks closes every bank whatever the select bits.
// - Refresh encoding starts timed renewal or retention by clock enable.
// - Primary and extended mode registers load from address inputs.
// - Busy banks accept only deselect, idle cycle, close while precharging.
// - Idle: refresh, retention and mode load accepted; reads, writes illegal.
// - Active bank: reads start bursts, halt idles, row open illegal.
// - Active bank: store bursts start writes into the open row.
// - Active bank: closes move the bank or banks to precharging.
// - Closed bank stays precharging for row-precharge time, then idle.
// - Opened bank stays activating for row-to-column delay, then active.
// - Renewal keeps the device in refresh for the refresh cycle time.
// - Commands illegal for a busy bank may target other ready banks.
`timescale 1ns/1ps
`default_nettype none
module sdc_command_bank_fsm import sdc_pkg::*; (
  input  wire logic                        i_clock,
  input  wire logic                        i_rst_b,
  input  wire sdc_pins_s                   i_pins,
  output var  sdc_bank_e [NBANK-1:0]       o_bank_state,
  output logic [NBANK-1:0][ROW_W-1:0]      o_row,
  output var  sdc_burst_s                  o_burst,
  output logic                             o_dq_oe,
  output logic [ADDR_W-1:0]                o_mode,
  output logic [ADDR_W-1:0]                o_ext_mode,
  output logic                             o_illegal
);

  // ****************************************
  // Helpers
  // ****************************************
  // Precharging, activating and refresh are the busy states
  function automatic logic is_busy(input sdc_bank_e s);
    return (s == BK_PRECHG) || (s == BK_ACTVTG) || (s == BK_REFRESH);
  endfunction : is_busy

  // Bank tied up by an autoclose burst or its write recovery
  function automatic logic is_locked(input sdc_core_s c, input logic [1:0] b);
    return (c.burst.active && c.burst.autoclose && (c.burst.bank == b)) ||
           (c.rec_pending && (c.rec_bank == b));
  endfunction : is_locked

  sdc_cmd_s             cmd;
  sdc_core_s            cur;
  sdc_core_s            next_cur;
  logic [NBANK-1:0]     open_p;
  logic [NBANK-1:0]     close_p;
  logic                 renew_p;
  logic                 retain_p;
  logic                 start_p;
  logic                 halt_p;
  logic                 kill_p;
  logic                 bdone;
  logic                 all_idle;
  sdc_bank_e            sel_st;

  // ****************************************
  // Command decode and banks
  // ****************************************
  sdc_cmd_decode u_decode (
    .i_pins (i_pins),
    .o_cmd  (cmd)
  );

  for (genvar b = 0; b < NBANK; b++) begin : g_bank
    sdc_bank u_bank (
      .i_clock   (i_clock),
      .i_rst_b   (i_rst_b),
      .i_open    (open_p[b]),
      .i_close   (close_p[b]),
      .i_refresh (renew_p),
      .i_retain  (retain_p),
      .i_cke     (i_pins.cke),
      .o_state   (o_bank_state[b])
    );
  end

  // Selected bank state and the all-idle condition
  // judged across every bank; sel_st from the addressed bank
  always_comb begin
    sel_st   = o_bank_state[cmd.bank];
    all_idle = 1'b1;
    for (int b = 0; b < NBANK; b++) begin
      if (o_bank_state[b] != BK_IDLE) begin
        all_idle = 1'b0;
      end
    end
  end

  // ****************************************
  // Command judging
  // ****************************************
  // Illegal commands raise the flag and take no action
  always_comb begin
    next_cur         = cur;
    next_cur.illegal = 1'b0;
    open_p           = '0;
    close_p          = '0;
    renew_p          = 1'b0;
    retain_p         = 1'b0;
    start_p          = 1'b0;
    halt_p           = 1'b0;
    kill_p           = 1'b0;
    case (cmd.cmd)
      CMD_DESELECT_IGNORE,
      CMD_IDLE_CYCLE: begin
      end
      CMD_BURST_HALT: begin
        // Halting an autoclose burst would lose its close
        if (cur.burst.active && cur.burst.autoclose) begin
          next_cur.illegal = 1'b1;
        end else if (cur.burst.active) begin
          halt_p = 1'b1;
        end else if (cur.rec_pending || is_busy(sel_st)) begin
          next_cur.illegal = 1'b1;
        end
      end
      CMD_READ,
      CMD_STORE_BURST: begin
        if ((sel_st != BK_ACTIVE) || is_locked(cur, cmd.bank)) begin
          next_cur.illegal = 1'b1;
        end else if ((cmd.cmd == CMD_STORE_BURST) && cur.burst.active && !cur.burst.write) begin
          next_cur.illegal = 1'b1;
        end else begin
          start_p = 1'b1;
        end
      end
      // row open on idle bank only
      CMD_ROW_OPEN: begin
        if (sel_st != BK_IDLE) begin
          next_cur.illegal = 1'b1;
        end else begin
          open_p[cmd.bank] = 1'b1;
          next_cur.row[cmd.bank] = cmd.addr[ROW_W-1:0];
        end
      end
      CMD_BANK_CLOSE: begin
        if ((sel_st == BK_ACTVTG) || (sel_st == BK_REFRESH) || is_locked(cur, cmd.bank)) begin
          next_cur.illegal = 1'b1;
        end else if (sel_st == BK_ACTIVE) begin
          close_p[cmd.bank] = 1'b1;
          kill_p = cur.burst.active && (cur.burst.bank == cmd.bank);
        end
      end
      CMD_CLOSE_ALL_BANKS: begin
        // One unready bank refuses the lot; no partial close
        next_cur.illegal = cur.rec_pending || (cur.burst.active && cur.burst.autoclose);
        for (int b = 0; b < NBANK; b++) begin
          if ((o_bank_state[b] == BK_ACTVTG) || (o_bank_state[b] == BK_REFRESH)) begin
            next_cur.illegal = 1'b1;
          end
        end
        if (!next_cur.illegal) begin
          for (int b = 0; b < NBANK; b++) begin
            close_p[b] = (o_bank_state[b] == BK_ACTIVE);
          end
          kill_p = cur.burst.active;
        end
      end
      // renewal or retention by clock enable
      CMD_ROW_RENEWAL,
      CMD_RETENTION: begin
        // refresh only with all banks idle
        if (!all_idle) begin
          next_cur.illegal = 1'b1;
        end else begin
          renew_p  = (cmd.cmd == CMD_ROW_RENEWAL);
          retain_p = (cmd.cmd == CMD_RETENTION);
        end
      end
      CMD_MODE_LOAD,
      CMD_EXT_MODE_LOAD: begin
        if (!all_idle) begin
          next_cur.illegal = 1'b1;
        end else if (cmd.cmd == CMD_MODE_LOAD) begin
          next_cur.mode = cmd.addr;
        end else begin
          next_cur.ext_mode = cmd.addr;
        end
      end
      default: next_cur.illegal = 1'b1;
    endcase

    // ****************************************
    // Burst engine
    // ****************************************
    // A burst ends on its last beat, on halt, on a close, or when replaced
    bdone = cur.burst.active && ((cur.bcnt == 4'h0) || start_p || halt_p || kill_p);
    if (cur.burst.active && (cur.bcnt != 4'h0)) begin
      next_cur.bcnt = cur.bcnt - 4'h1;
    end
    // Write recovery before an automatic close
    if (cur.rec_pending) begin
      if (cur.rec_cnt == 4'h0) begin
        close_p[cur.rec_bank] = 1'b1;
        next_cur.rec_pending  = 1'b0;
      end else begin
        next_cur.rec_cnt = cur.rec_cnt - 4'h1;
      end
    end
    if (bdone) begin
      next_cur.burst.active = 1'b0;
      if (cur.burst.autoclose && !kill_p) begin
        if (cur.burst.write) begin
          // Single recovery slot; a second autoclose write ending overwrites a pending one
          next_cur.rec_pending = 1'b1;
          next_cur.rec_bank    = cur.burst.bank;
          next_cur.rec_cnt     = TWR_LOAD;
        end else begin
          close_p[cur.burst.bank] = 1'b1;
        end
      end
    end
    // new burst takes column and bank
    if (start_p) begin
      next_cur.burst.active    = 1'b1;
      // store burst writes the open row
      next_cur.burst.write     = (cmd.cmd == CMD_STORE_BURST);
      next_cur.burst.autoclose = cmd.autoclose;
      next_cur.burst.bank      = cmd.bank;
      next_cur.burst.col       = cmd.addr[COL_W-1:0];
      next_cur.bcnt            = BURST_LOAD;
    end
    // drivers on only during a read burst
    next_cur.dq_oe = next_cur.burst.active && !next_cur.burst.write;
  end

  // State register
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      cur <= CORE_RST;
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs straight from flops
  assign o_row      = cur.row;
  assign o_burst    = cur.burst;
  assign o_dq_oe    = cur.dq_oe;
  assign o_mode     = cur.mode;
  assign o_ext_mode = cur.ext_mode;
  assign o_illegal  = cur.illegal;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  idle_hold_a: assert property (
    (cmd.cmd == CMD_IDLE_CYCLE) && !cur.burst.active && !cur.rec_pending
      |=> $stable(o_row) && $stable(o_mode) && $stable(o_ext_mode) && !o_illegal)
    else $error("idle cycle changed state");
  halt_ends_a: assert property (
    (cmd.cmd == CMD_BURST_HALT) && o_burst.active && !o_burst.autoclose
      |=> !o_burst.active && !o_dq_oe)
    else $error("halt did not end burst");
  read_start_a: assert property (
    (cmd.cmd == CMD_READ) && (sel_st == BK_ACTIVE) && !is_locked(cur, cmd.bank)
      |=> o_burst.active && !o_burst.write && o_dq_oe && (o_burst.col == $past(cmd.addr[COL_W-1:0])))
    else $error("read burst not started");
  dq_release_a: assert property (
    o_dq_oe && (cur.bcnt == 4'h0) && (cmd.cmd == CMD_IDLE_CYCLE) |=> !o_dq_oe)
    else $error("drivers not released");
  read_close_a: assert property (
    o_burst.active && !o_burst.write && o_burst.autoclose && (cur.bcnt == 4'h0)
      |-> close_p[o_burst.bank])
    else $error("autoclose read did not close");
  write_close_a: assert property (
    o_burst.active && o_burst.write && o_burst.autoclose && (cur.bcnt == 4'h0) && !kill_p
      |=> cur.rec_pending ##2 close_p[$past(o_burst.bank, 3)])
    else $error("autoclose write did not close");
  row_latch_a: assert property (
    (cmd.cmd == CMD_ROW_OPEN) && (sel_st == BK_IDLE)
      |=> (o_row[$past(cmd.bank)] == $past(cmd.addr[ROW_W-1:0])) && (o_bank_state[$past(cmd.bank)] == BK_ACTVTG))
    else $error("row open not taken");
  close_one_a: assert property (
    (cmd.cmd == CMD_BANK_CLOSE) && (sel_st == BK_ACTIVE) && !is_locked(cur, cmd.bank)
      |-> (close_p == (4'h1 << cmd.bank)) || cur.rec_pending)
    else $error("wrong bank closed");
  close_all_a: assert property (
    (cmd.cmd == CMD_CLOSE_ALL_BANKS) && !next_cur.illegal
      |=> (o_bank_state[0] != BK_ACTIVE) && (o_bank_state[1] != BK_ACTIVE) &&
          (o_bank_state[2] != BK_ACTIVE) && (o_bank_state[3] != BK_ACTIVE))
    else $error("close all left a bank open");
  mode_load_a: assert property (
    (cmd.cmd == CMD_MODE_LOAD) && all_idle |=> (o_mode == $past(cmd.addr)) && $stable(o_ext_mode))
    else $error("mode register not loaded");
  busy_flag_a: assert property (
    ((cmd.cmd == CMD_READ) || (cmd.cmd == CMD_ROW_OPEN)) && is_busy(sel_st)
      |=> o_illegal && $stable(o_row))
    else $error("busy bank accepted command");
  refresh_all_a: assert property (
    (cmd.cmd == CMD_ROW_RENEWAL) && all_idle
      |=> (o_bank_state == {NBANK{BK_REFRESH}}))
    else $error("refresh not started");

  write_start_a: assert property (
    (cmd.cmd == CMD_STORE_BURST) && (sel_st == BK_ACTIVE) && !is_locked(cur, cmd.bank) &&
      !(o_burst.active && !o_burst.write) |=> o_burst.active && o_burst.write && !o_dq_oe &&
      (o_burst.bank == $past(cmd.bank)))
    else $error("write burst not started");
  retain_start_a: assert property (
    (cmd.cmd == CMD_RETENTION) && all_idle |=> (o_bank_state == {NBANK{BK_REFRESH}}))
    else $error("retention not started");
  halt_idle_a: assert property (
    (cmd.cmd == CMD_BURST_HALT) && !o_burst.active && !cur.rec_pending && (sel_st == BK_IDLE)
      |=> !o_illegal)
    else $error("halt on idle bank refused");
  open_active_a: assert property (
    (cmd.cmd == CMD_ROW_OPEN) && (sel_st == BK_ACTIVE) |=> o_illegal && $stable(o_row))
    else $error("row open on active bank taken");
  illegal_still_a: assert property (
    o_illegal |-> $stable(o_row) && $stable(o_mode) && $stable(o_ext_mode))
    else $error("illegal command changed state");
  close_active_a: assert property (
    (cmd.cmd == CMD_BANK_CLOSE) && (sel_st == BK_ACTIVE) && !is_locked(cur, cmd.bank)
      |=> (o_bank_state[$past(cmd.bank)] == BK_PRECHG))
    else $error("active bank not closing");

  read_burst_c: cover property (
    (cmd.cmd == CMD_READ) && (sel_st == BK_ACTIVE) ##1 o_dq_oe [*4] ##1 !o_dq_oe);
  write_auto_c: cover property (
    o_burst.active && o_burst.write && o_burst.autoclose ##[1:8] cur.rec_pending);
  refresh_c: cover property (renew_p ##1 (o_bank_state[0] == BK_REFRESH));
  illegal_c: cover property (o_illegal);
  halt_c: cover property (halt_p ##1 !o_burst.active);

endmodule : sdc_command_bank_fsm
`default_nettype wire

// *** rtl/sdc_pkg.sv ***
package sdc_pkg;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int NBANK          = 4;
  localparam int ROW_W          = 13;
  localparam int COL_W          = 10;
  localparam int ADDR_W         = 13;
  localparam int AUTOCLOSE_BIT  = 10;
  localparam logic [1:0] SEL_MODE     = 2'h0;
  localparam logic [1:0] SEL_EXT_MODE = 2'h2;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_PS = 10000;
  localparam int TRP_NS        = 20;
  localparam int TRCD_NS       = 20;
  localparam int TRFC_TCK      = 15;
  localparam int TWR_TCK       = 3;
  localparam int BURST_TCK     = 4;
  // Least times round up to whole cycles
  localparam int TRP_CYC  = (TRP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TRCD_CYC = (TRCD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0] TRP_LOAD   = 4'(TRP_CYC - 1);
  localparam logic [3:0] TRCD_LOAD  = 4'(TRCD_CYC - 1);
  localparam logic [3:0] TRFC_LOAD  = 4'(TRFC_TCK - 1);
  localparam logic [3:0] TWR_LOAD   = 4'(TWR_TCK - 1);
  localparam logic [3:0] BURST_LOAD = 4'(BURST_TCK - 1);

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [4:0] {
    BK_PRECHG  = 5'h01,
    BK_IDLE    = 5'h02,
    BK_REFRESH = 5'h04,
    BK_ACTVTG  = 5'h08,
    BK_ACTIVE  = 5'h10
  } sdc_bank_e;

  typedef enum logic [3:0] {
    CMD_DESELECT_IGNORE = 4'h0,
    CMD_IDLE_CYCLE      = 4'h1,
    CMD_BURST_HALT      = 4'h2,
    CMD_READ            = 4'h3,
    CMD_STORE_BURST     = 4'h4,
    CMD_ROW_OPEN        = 4'h5,
    CMD_BANK_CLOSE      = 4'h6,
    CMD_CLOSE_ALL_BANKS = 4'h7,
    CMD_ROW_RENEWAL     = 4'h8,
    CMD_RETENTION       = 4'h9,
    CMD_MODE_LOAD       = 4'ha,
    CMD_EXT_MODE_LOAD   = 4'hb,
    CMD_BAD             = 4'hc
  } sdc_cmd_e;

  typedef struct packed {
    logic              cs_b;
    logic              ras_b;
    logic              cas_b;
    logic              we_b;
    logic              cke;
    logic [1:0]        bank_sel;
    logic [ADDR_W-1:0] addr;
  } sdc_pins_s;

  typedef struct packed {
    sdc_cmd_e          cmd;
    logic [1:0]        bank;
    logic              autoclose;
    logic [ADDR_W-1:0] addr;
  } sdc_cmd_s;

  typedef struct packed {
    logic             active;
    logic             write;
    logic             autoclose;
    logic [1:0]       bank;
    logic [COL_W-1:0] col;
  } sdc_burst_s;

  typedef struct packed {
    sdc_bank_e  st;
    logic       retain;
    logic [3:0] cnt;
  } sdc_bank_s;

  typedef struct packed {
    sdc_burst_s                   burst;
    logic [3:0]                   bcnt;
    logic                         rec_pending;
    logic [1:0]                   rec_bank;
    logic [3:0]                   rec_cnt;
    logic                         dq_oe;
    logic                         illegal;
    logic [ADDR_W-1:0]            mode;
    logic [ADDR_W-1:0]            ext_mode;
    logic [NBANK-1:0][ROW_W-1:0]  row;
  } sdc_core_s;

  localparam sdc_bank_s BANK_RST = '{st: BK_IDLE, retain: 1'b0, cnt: 4'h0};
  localparam sdc_core_s CORE_RST = '0;

endpackage : sdc_pkg
